// ==== brrp_consts.svh ====
// ---------------------------------------------------------------------------
// brrp constants: sizes, flag thresholds and reset values of the fifo ram
// ---------------------------------------------------------------------------
// assumes: included by bare name from the package and the design modules.
`ifndef BRRP_CONSTS_SVH
`define BRRP_CONSTS_SVH

// ---------------------------------------------------------------------------
// data path shape
// ---------------------------------------------------------------------------
`define BRRP_LANE_W 8
`define BRRP_LANES 2
`define BRRP_DATA_W 16

// ---------------------------------------------------------------------------
// storage depth and flag thresholds (defaults of the top parameters)
// ---------------------------------------------------------------------------
`define BRRP_DEPTH 16
`define BRRP_ADDR_W 4
`define BRRP_AF_LEVEL 12
`define BRRP_AE_LEVEL 4

// ---------------------------------------------------------------------------
// reset values of the status flags
// ---------------------------------------------------------------------------
`define BRRP_FLAGS_RST 4'h1

`endif

// ==== brrp_pkg.sv ====
// ---------------------------------------------------------------------------
// brrp package: carrier types of the fifo ram
// ---------------------------------------------------------------------------
// assumes: the constants header is on the include path.
`include "brrp_consts.svh"

package brrp_pkg;

  // one write request: data word plus its lane enables
  typedef struct packed {
    logic [`BRRP_LANES-1:0] lanes;
    logic [`BRRP_DATA_W-1:0] data;
  } brrp_wreq_t;

  // status flags, order fixed: almost full, full, almost empty, empty
  typedef struct packed {
    logic almost_full;
    logic full;
    logic almost_empty;
    logic empty;
  } brrp_flags_t;

endpackage : brrp_pkg

// ==== brrp_skid.sv ====
// ---------------------------------------------------------------------------
// brrp_skid: two-entry buffer with valid/ready on both sides
// ---------------------------------------------------------------------------
// assumes: one clock; the owner folds its asynchronous clears, except the read pointer clear, into rst_n_in.
`timescale 1ns/100ps
`include "brrp_consts.svh"

module brrp_skid #(
  parameter int WIDTH = `BRRP_DATA_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  // ---------------------------------------------------------------------------
  // storage: head feeds the output, tail catches a word during a stall
  // ---------------------------------------------------------------------------
  logic [WIDTH-1:0] head_ff; // word presented downstream
  logic [WIDTH-1:0] tail_ff; // second word held while stalled
  logic [1:0] cnt_ff; // words held, 0..2
  logic valid_ff; // registered copy of a non-zero count

  wire logic push = ce_in && in_valid_in && (cnt_ff != 2'h2);
  wire logic pop = ce_in && out_ready_in && (cnt_ff != 2'h0);
  wire logic [1:0] nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};

  // ready straight from the count, so a stalled receiver stops the source
  assign in_ready_out = (cnt_ff != 2'h2);
  // valid from its own flop, so the owner's output has no gate after it
  assign out_valid_out = valid_ff;
  assign out_data_out = head_ff;

  // ---------------------------------------------------------------------------
  // occupancy and data movement
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 2'h0;
      valid_ff <= 1'b0;
      head_ff <= '0;
      tail_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      valid_ff <= (nxt_cnt != 2'h0);
      // head refills from tail on a pop with two held, or from input when empty or going empty
      if (pop && cnt_ff == 2'h2) begin
        head_ff <= tail_ff;
      end else if (push && (cnt_ff == 2'h0 || (pop && cnt_ff == 2'h1))) begin
        head_ff <= in_data_in;
      end
      // tail only loads when head stays occupied
      if (push && cnt_ff != 2'h0 && !(pop && cnt_ff == 2'h1)) begin
        tail_ff <= in_data_in;
      end
    end
  end

endmodule : brrp_skid

// ==== brrp_fifo_ram.sv ====
// ---------------------------------------------------------------------------
// brrp_fifo_ram: block ram in fifo mode with asynchronous resets
// ---------------------------------------------------------------------------
// holds the storage, pointers, status flags and the output buffer.
// assumes: user fabric drives every input synchronous to clk_in and keeps
// the enable/reset ordering itself; the ram is only told, not protected.
`timescale 1ns/100ps
`include "brrp_consts.svh"

module brrp_fifo_ram #(
  parameter int DEPTH = `BRRP_DEPTH,
  parameter int ADDR_W = `BRRP_ADDR_W,
  parameter int AF_LEVEL = `BRRP_AF_LEVEL,
  parameter int AE_LEVEL = `BRRP_AE_LEVEL
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic global_set_reset_in,
  input wire logic port_reset_in,
  input wire logic read_pointer_clear_pin_in,
  input wire logic wr_port_select_in,
  input wire logic full_in,
  input wire logic wr_en_in,
  input wire brrp_pkg::brrp_wreq_t wr_req_in,
  input wire logic rd_port_select_in,
  input wire logic empty_in,
  input wire logic pop_gate_in,
  input wire logic output_fetch_enable_in,
  input wire logic output_register_gate_in,
  input wire logic rd_ready_in,
  output logic rd_valid_out,
  output logic [`BRRP_DATA_W-1:0] rd_data_out,
  output brrp_pkg::brrp_flags_t flags_out
);

  // ---------------------------------------------------------------------------
  // asynchronous clears
  // ---------------------------------------------------------------------------
  // global set/reset is never masked in fifo mode, so it joins the port
  // reset; both act on the flops at once, no clock edge needed
  // no ordering guard: enable/reset sequencing stays the user's duty
  wire logic arst_n = rst_n_in && !global_set_reset_in && !port_reset_in;
  // pointer clear only rewinds the read side
  wire logic rd_arst_n = arst_n && !read_pointer_clear_pin_in;

  // ---------------------------------------------------------------------------
  // pointers and occupancy
  // ---------------------------------------------------------------------------
  logic [ADDR_W:0] wr_ptr_ff; // write pointer with wrap bit
  logic [ADDR_W:0] rd_ptr_ff; // read pointer with wrap bit
  brrp_pkg::brrp_flags_t flags_ff; // registered status flags
  wire logic [ADDR_W:0] level = wr_ptr_ff - rd_ptr_ff; // words stored
  wire logic [ADDR_W:0] depth_c = (ADDR_W+1)'(DEPTH);

  // ---------------------------------------------------------------------------
  // port gating: selects, full/empty inputs and enables all active high
  // ---------------------------------------------------------------------------
  logic buf_in_ready; // output buffer has room
  // full_in is just another write select
  wire logic wr_sel = wr_port_select_in && full_in;
  // empty_in is just another read select
  wire logic rd_sel = rd_port_select_in && empty_in;
  // write enable doubles as the write-side clock enable
  wire logic wr_go = ce_in && wr_en_in && wr_sel && (level != depth_c);
  // a pop needs room downstream, so a stalled reader loses nothing
  wire logic rd_go = ce_in && pop_gate_in && rd_sel && output_fetch_enable_in
                     && (level != '0) && buf_in_ready
                     && !read_pointer_clear_pin_in;
  wire logic [ADDR_W:0] nxt_wr_ptr = wr_ptr_ff + {{ADDR_W{1'b0}}, wr_go};
  wire logic [ADDR_W:0] nxt_rd_ptr = rd_ptr_ff + {{ADDR_W{1'b0}}, rd_go};
  wire logic [ADDR_W:0] nxt_level = nxt_wr_ptr - nxt_rd_ptr;

  // flags follow the level after this edge
  brrp_pkg::brrp_flags_t nxt_flags;
  assign nxt_flags.almost_full = (nxt_level >= (ADDR_W+1)'(AF_LEVEL));
  assign nxt_flags.full = (nxt_level == depth_c);
  assign nxt_flags.almost_empty = (nxt_level <= (ADDR_W+1)'(AE_LEVEL));
  assign nxt_flags.empty = (nxt_level == '0);

  // ---------------------------------------------------------------------------
  // storage: one array per byte lane so lane enables never collide
  // ---------------------------------------------------------------------------
  // contents are not cleared by any reset; a preloaded image survives
  logic [`BRRP_DATA_W-1:0] rd_word; // word at the read pointer
  genvar g;
  generate
    for (g = 0; g < `BRRP_LANES; g++) begin : g_lane
      logic [`BRRP_LANE_W-1:0] mem [DEPTH]; // lane storage
      // lane written only when its enable is high
      always_ff @(posedge clk_in) begin
        if (wr_go && wr_req_in.lanes[g]) begin
          mem[wr_ptr_ff[ADDR_W-1:0]] <= wr_req_in.data[g*`BRRP_LANE_W +: `BRRP_LANE_W];
        end
      end
      assign rd_word[g*`BRRP_LANE_W +: `BRRP_LANE_W] = mem[rd_ptr_ff[ADDR_W-1:0]];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // pointer and flag registers
  // ---------------------------------------------------------------------------
  // write side cleared by global or port reset
  always_ff @(posedge clk_in or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= '0;
      flags_ff <= `BRRP_FLAGS_RST;
    end else if (ce_in) begin
      wr_ptr_ff <= nxt_wr_ptr;
      flags_ff <= nxt_flags;
    end
  end

  // read side also cleared by the pointer clear pin
  always_ff @(posedge clk_in or negedge rd_arst_n) begin
    if (!rd_arst_n) begin
      rd_ptr_ff <= '0;
    end else if (ce_in) begin
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  assign flags_out = flags_ff;

  // ---------------------------------------------------------------------------
  // output register: two-entry buffer, drained only while the gate is high
  // ---------------------------------------------------------------------------
  brrp_skid #(
    .WIDTH(`BRRP_DATA_W)
  ) u_out_buf (
    .clk_in(clk_in),
    .rst_n_in(arst_n),
    .ce_in(ce_in),
    .in_valid_in(rd_go),
    .in_ready_out(buf_in_ready),
    .in_data_in(rd_word),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in && output_register_gate_in),
    .out_data_out(rd_data_out)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_gsr_clears_wr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    global_set_reset_in |-> (wr_ptr_ff == '0 && rd_ptr_ff == '0 && !rd_valid_out))
    else $error("global set/reset did not clear pointers");

  a_rpclr_async: assert property (@(posedge clk_in) disable iff (!arst_n)
    read_pointer_clear_pin_in |-> (rd_ptr_ff == '0))
    else $error("pointer clear did not act at once");

  a_full_in_gates: assert property (@(posedge clk_in) disable iff (!arst_n)
    (!full_in || !wr_port_select_in) |=> (wr_ptr_ff == $past(wr_ptr_ff)))
    else $error("write taken while write side deselected");

  a_empty_in_gates: assert property (@(posedge clk_in)
    disable iff (!rd_arst_n)
    (!empty_in || !rd_port_select_in) ##1 !read_pointer_clear_pin_in
    |-> (rd_ptr_ff == $past(rd_ptr_ff)))
    else $error("read taken while read side deselected");

  a_write_steps: assert property (@(posedge clk_in) disable iff (!arst_n)
    (ce_in && wr_en_in && wr_sel && level < depth_c)
    |=> (wr_ptr_ff == $past(wr_ptr_ff) + (ADDR_W+1)'(1)))
    else $error("enabled write did not advance pointer");

  a_ce_freeze: assert property (@(posedge clk_in) disable iff (!rd_arst_n)
    (!ce_in ##1 !read_pointer_clear_pin_in)
    |-> ($stable(wr_ptr_ff) && $stable(rd_ptr_ff) && $stable(flags_ff)))
    else $error("state moved with clock enable low");

  a_flags_full: assert property (@(posedge clk_in) disable iff (!rd_arst_n)
    !$past(read_pointer_clear_pin_in)
    |-> (flags_ff.full == (level == depth_c) && flags_ff.empty == (level == '0)))
    else $error("full/empty flag disagrees with level");

  // reset value leaves almost empty low until the first enabled edge
  a_flags_almost: assert property (@(posedge clk_in) disable iff (!rd_arst_n)
    !$past(read_pointer_clear_pin_in) && $past(arst_n)
    |-> (flags_ff.almost_full == (level >= (ADDR_W+1)'(AF_LEVEL))
         && flags_ff.almost_empty == (level <= (ADDR_W+1)'(AE_LEVEL))))
    else $error("almost flags disagree with level");

  a_pop_delivers: assert property (@(posedge clk_in) disable iff (!rd_arst_n)
    rd_go |=> rd_valid_out)
    else $error("pop did not reach the output buffer");

  // port reset must clear both sides at once
  a_prst_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    port_reset_in |-> (wr_ptr_ff == '0 && rd_ptr_ff == '0 && !rd_valid_out))
    else $error("port reset did not clear pointers");

  // a full store refuses every write
  a_full_no_write: assert property (@(posedge clk_in) disable iff (!arst_n)
    (level == depth_c) |=> (wr_ptr_ff == $past(wr_ptr_ff)))
    else $error("write taken while full");

  // an empty store refuses every pop
  a_empty_no_pop: assert property (@(posedge clk_in) disable iff (!rd_arst_n)
    (level == '0) ##1 !read_pointer_clear_pin_in
    |-> (rd_ptr_ff == $past(rd_ptr_ff)))
    else $error("pop taken while empty");

  // an accepted pop advances the read pointer by one
  a_pop_steps: assert property (@(posedge clk_in) disable iff (!rd_arst_n)
    rd_go |=> (rd_ptr_ff == $past(rd_ptr_ff) + (ADDR_W+1)'(1)))
    else $error("pop did not advance pointer");

  // a word stands until the receiver takes it
  a_valid_holds: assert property (@(posedge clk_in) disable iff (!arst_n)
    (rd_valid_out && !(ce_in && rd_ready_in && output_register_gate_in))
    |=> (rd_valid_out && $stable(rd_data_out)))
    else $error("output word dropped before it was taken");

  // output fetch enable low blocks pops
  a_fetch_gates: assert property (@(posedge clk_in) disable iff (!rd_arst_n)
    !output_fetch_enable_in ##1 !read_pointer_clear_pin_in
    |-> (rd_ptr_ff == $past(rd_ptr_ff)))
    else $error("pop taken with fetch enable low");

  // read enable acts as the read side clock enable
  a_pop_gate_off: assert property (@(posedge clk_in) disable iff (!rd_arst_n)
    !pop_gate_in ##1 !read_pointer_clear_pin_in
    |-> (rd_ptr_ff == $past(rd_ptr_ff)))
    else $error("pop taken with read enable low");

  // write enable acts as the write side clock enable
  a_wr_en_off: assert property (@(posedge clk_in) disable iff (!arst_n)
    !wr_en_in |=> (wr_ptr_ff == $past(wr_ptr_ff)))
    else $error("write taken with write enable low");

endmodule : brrp_fifo_ram

// ==== brrp_fabric_model.sv ====
// brrp_fabric_model: user fabric on the read side, taking words off the ram
// assumes: one clock; the bench reads the collected words from got
`timescale 1ns/100ps
`include "brrp_consts.svh"

module brrp_fabric_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic stall_in,
  input wire logic ce_in,
  input wire logic gate_in,
  input wire logic rd_valid_in,
  input wire logic [`BRRP_DATA_W-1:0] rd_data_in,
  output logic rd_ready_out
);
  // ---------------------------------------------------------------------------
  // receiver pacing and capture
  // ---------------------------------------------------------------------------
  logic [1:0] phase_ff; // stall pattern: ready one cycle in four
  logic [`BRRP_DATA_W-1:0] got[$]; // words taken, oldest first

  // free running phase, so stalls hit the buffer at varying levels
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // ready only changes after an edge, held until sampled
  assign rd_ready_out = !stall_in || (phase_ff == 2'h3);

  // a word counts only where the ram's own drain condition holds
  always @(posedge clk_in) begin
    if (ce_in && gate_in && rd_valid_in && rd_ready_out) begin
      got.push_back(rd_data_in);
    end
  end
endmodule : brrp_fabric_model

// ==== testbench.sv ====
// testbench: self-checking bench of brrp_fifo_ram with a read-side fabric model
// assumes: the design package and constants header compile first
`timescale 1ns/100ps
`include "brrp_consts.svh"

module testbench;
  // ---------------------------------------------------------------------------
  // stimulus signals, all given a value at time zero
  // ---------------------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic global_set_reset = 1'b0; // global set/reset
  logic prst = 1'b0; // port reset
  logic rpc = 1'b0; // read pointer clear
  logic wr_en = 1'b0;
  logic pop = 1'b0;
  logic stall = 1'b0;
  logic ce = 1'b1; // clock enable of ram and fabric
  logic [4:0] gates = 5'h1F; // wr sel, full_in, rd sel, empty_in, fetch
  brrp_pkg::brrp_wreq_t wr_req = '0;
  logic rd_ready;
  logic rd_valid;
  logic [`BRRP_DATA_W-1:0] rd_data;
  brrp_pkg::brrp_flags_t flags;
  int failures = 0;
  int compares = 0;

  brrp_fifo_ram dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .global_set_reset_in(global_set_reset), .port_reset_in(prst), .read_pointer_clear_pin_in(rpc),
    .wr_port_select_in(gates[4]), .full_in(gates[3]), .wr_en_in(wr_en), .wr_req_in(wr_req),
    .rd_port_select_in(gates[2]), .empty_in(gates[1]), .pop_gate_in(pop),
    .output_fetch_enable_in(gates[0]), .output_register_gate_in(1'b1),
    .rd_ready_in(rd_ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data), .flags_out(flags));

  brrp_fabric_model fab (.clk_in(clk_in), .rst_n_in(rst_n_in), .stall_in(stall), .ce_in(ce),
    .gate_in(1'b1), .rd_valid_in(rd_valid), .rd_data_in(rd_data), .rd_ready_out(rd_ready));

  // 50 MHz clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end

  // ---------------------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------------------
  // compare and count; hex values in the report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one write per edge; bursts stay high, stop_wr ends them
  task automatic put(input logic [15:0] d, input logic [1:0] ln);
    @(posedge clk_in);
    wr_en <= 1'b1;
    wr_req <= '{lanes: ln, data: d};
  endtask : put

  task automatic stop_wr();
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask : stop_wr

  // bounded wait for the fabric to have collected n words
  task automatic wait_got(input int n);
    repeat (400) begin
      if (fab.got.size() >= n) break;
      @(posedge clk_in);
    end
  endtask : wait_got

  // single pop, taken at the edge after it is raised
  task automatic pop1();
    @(posedge clk_in);
    pop <= 1'b1;
    @(posedge clk_in);
    pop <= 1'b0;
  endtask : pop1

  // enables parked low a cycle either side; reset hit between edges on purpose
  task automatic clr(input int kind);
    @(posedge clk_in);
    wr_en <= 1'b0;
    pop <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
    case (kind)
      0: global_set_reset = 1'b1;
      1: prst = 1'b1;
      default: rst_n_in = 1'b0;
    endcase
    #2;
    chk({12'h000, flags}, 16'h0001);
    chk({15'h0000, rd_valid}, 16'h0000);
    @(negedge clk_in);
    global_set_reset = 1'b0;
    prst = 1'b0;
    rst_n_in = 1'b1;
    @(posedge clk_in);
  endtask : clr

  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    final_report();
  end

  // ---------------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_in);
    chk({12'h000, flags}, 16'h0001);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    chk({12'h000, flags}, 16'h0003);
    $display("test reset done");
    // fill past the top: the seventeenth write must be dropped
    for (int i = 0; i < 17; i++) put(16'hA000 + 16'(i), 2'h3);
    stop_wr();
    @(negedge clk_in);
    chk({12'h000, flags}, 16'h000C);
    // drain against a stalling receiver, extra pops on empty ignored
    @(posedge clk_in);
    stall <= 1'b1;
    pop <= 1'b1;
    wait_got(16);
    repeat (4) @(posedge clk_in);
    pop <= 1'b0;
    stall <= 1'b0;
    chk(16'(fab.got.size()), 16'h0010);
    for (int i = 0; i < 16; i++) chk(fab.got[i], 16'hA000 + 16'(i));
    @(negedge clk_in);
    chk({12'h000, flags}, 16'h0003);
    fab.got.delete();
    $display("test fill and drain done");
    // each select on its own must gate its port
    put(16'h1234, 2'h3);
    stop_wr();
    for (int k = 3; k < 5; k++) begin
      @(posedge clk_in);
      gates <= 5'h1F ^ (5'h01 << k);
      put(16'h5550, 2'h3);
      stop_wr();
      gates <= 5'h1F;
      @(negedge clk_in);
      chk({12'h000, flags}, 16'h0002);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_in);
      gates <= 5'h1F ^ (5'h01 << k);
      pop <= 1'b1;
      @(posedge clk_in);
      pop <= 1'b0;
      gates <= 5'h1F;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk({15'h0000, rd_valid}, 16'h0000);
    end
    pop1();
    wait_got(1);
    chk(fab.got[0], 16'h1234);
    fab.got.delete();
    $display("test selects done");
    // global set/reset, port reset and rst_n_in clears, each with a word waiting
    for (int k = 0; k < 3; k++) begin
      put(16'h7000 + 16'(k), 2'h3);
      stop_wr();
      clr(k);
      @(negedge clk_in);
      chk({12'h000, flags}, 16'h0003);
    end
    $display("test async clears done");
    // pointer clear rewinds the read side only
    put(16'hC0DE, 2'h3);
    put(16'hBEEF, 2'h3);
    stop_wr();
    pop1();
    wait_got(1);
    @(negedge clk_in);
    rpc = 1'b1;
    @(negedge clk_in);
    rpc = 1'b0;
    @(posedge clk_in);
    pop <= 1'b1;
    wait_got(3);
    @(posedge clk_in);
    pop <= 1'b0;
    chk(fab.got[1], 16'hC0DE);
    chk(fab.got[2], 16'hBEEF);
    fab.got.delete();
    $display("test pointer clear done");
    // low lane only: upper byte of address 0 survives the reset
    clr(1);
    put(16'h1177, 2'h1);
    stop_wr();
    pop1();
    wait_got(1);
    chk(fab.got[0], 16'hC077);
    $display("test byte lanes done");
    // clock enable low: a write held up for cycles must not land
    @(posedge clk_in);
    ce <= 1'b0;
    put(16'h2222, 2'h3);
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk({12'h000, flags}, 16'h0003);
    stop_wr();
    ce <= 1'b1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk({12'h000, flags}, 16'h0003);
    $display("test clock enable done");
    final_report();
  end
endmodule : testbench
